// [hdl/ext_pin_irq_regs.svh]
// Register map, field positions, reset values for the pin interrupt flags.
// Assumes APB byte addressing; printed offsets are word indices.
`ifndef EXT_PIN_IRQ_REGS_SVH
`define EXT_PIN_IRQ_REGS_SVH
`define PIN01_FLAGS_INDEX    12'hFBE
`define KEY_SCAN_FLAGS_INDEX 12'hFBF
`define PIN01_FLAGS_ADDR     14'h3EF8
`define KEY_SCAN_FLAGS_ADDR  14'h3EFC
`define IRQ_STATUS_ADDR      14'h3F00
`define IRQ_MASK_ADDR        14'h3F04
`define EDGE_SELECT_ADDR     14'h3F08
`define SERVICE_ACK_ADDR     14'h3F0C
`define PIN_ONE_EN_BIT       3
`define PIN_ONE_REQ_BIT      2
`define PIN_ZERO_EN_BIT      1
`define PIN_ZERO_REQ_BIT     0
`define KEY_SCAN_EN_BIT      1
`define KEY_SCAN_REQ_BIT     0
`define PIN01_FLAGS_RESET    4'h0
`define KEY_SCAN_RESET       2'h0
`define STATUS_RESET         3'h0
`define MASK_RESET           3'h0
`define EDGE_SELECT_RESET    2'h0
`endif

// [hdl/ext_pin_irq_pkg.sv]
// Types shared by the pin interrupt flag block.
// Assumes nothing beyond the register header.
package ext_pin_irq_pkg;
  typedef enum logic [1:0] {
    src_pin_zero = 2'b00,
    src_pin_one  = 2'b01,
    src_key_scan = 2'b10
  } irq_source_t;
  typedef logic [2:0] src_vec_t;
endpackage

// [hdl/pin_sync_if.sv]
// Carrier between the top and the input synchroniser.
// Assumes one clock domain, pclk.
`timescale 1ns/10ps
interface pin_sync_if #(parameter int WIDTH = 10);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;
  modport owner (output raw, input synced, input rise, input fall);
  modport sync  (input raw, output synced, output rise, output fall);
endinterface

// [hdl/pin_edge_sync.sv]
// Two-flop synchroniser plus edge detection for asynchronous pins.
// Assumes pins idle high after reset (pull-ups).
`timescale 1ns/10ps
module pin_edge_sync #(
  parameter int WIDTH = 10
) (
  input  wire logic pclk,
  input  wire logic presetn,
  pin_sync_if.sync  pins
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] stage_old;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_one <= '1;
      stage_two <= '1;
      stage_old <= '1;
    end else begin
      stage_one <= pins.raw;
      stage_two <= stage_one;
      stage_old <= stage_two;
    end
  end

  assign pins.synced = stage_two;
  assign pins.rise   = stage_two & ~stage_old;
  assign pins.fall   = ~stage_two & stage_old;
endmodule

// [hdl/ext_pin_interrupt_flags.sv]
// Enable and request flags for two edge pins and an 8-pin key-scan group.
// Assumes an APB master on pclk; pins are asynchronous to pclk.
`timescale 1ns/10ps
`include "ext_pin_irq_regs.svh"

// How it works
// - Pins zero/one flags share one 4-bit register
// - Pin enable 0 blocks, 1 passes request to pin_zero_irq/pin_one_irq; irq ignores enables
// - Any key-scan falling edge sets key request
// - Key request cleared only by software
// - Key register: bits 3-2 undefined, enable, request
module ext_pin_interrupt_flags
  import ext_pin_irq_pkg::*;
#(
  parameter int KEY_PINS = 8
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                ext_pin_zero,
  input  wire logic                ext_pin_one,
  input  wire logic [KEY_PINS-1:0] key_scan_inputs,
  input  wire logic                pin_zero_service_ack,
  input  wire logic                pin_one_service_ack,
  output logic                     pin_zero_irq,
  output logic                     pin_one_irq,
  output logic                     key_scan_source,
  output logic                     irq
);
  localparam int NPINS = KEY_PINS + 2;

  logic [3:0] pin_flags;
  logic       key_scan_irq_enable;
  logic       key_scan_irq_request;
  src_vec_t   irq_status;
  src_vec_t   irq_mask;
  logic [1:0] edge_select;
  logic       wr;
  logic       rd;
  logic       hit;
  logic [13:0] addr;
  logic       event_zero;
  logic       event_one;
  logic       event_key;
  logic       ack_zero;
  logic       ack_one;
  src_vec_t   events;

  pin_sync_if #(.WIDTH(NPINS)) pins ();

  assign pins.raw = {key_scan_inputs, ext_pin_one, ext_pin_zero};

  pin_edge_sync #(.WIDTH(NPINS)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (pins)
  );

  // APB decode: zero wait states, unmapped addresses answer with an error
  assign addr    = paddr[13:0];
  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  always_comb begin
    hit = (paddr[31:14] == 18'h0) && (paddr[1:0] == 2'h0) &&
          (addr == `PIN01_FLAGS_ADDR || addr == `KEY_SCAN_FLAGS_ADDR ||
           addr == `IRQ_STATUS_ADDR  || addr == `IRQ_MASK_ADDR      ||
           addr == `EDGE_SELECT_ADDR || addr == `SERVICE_ACK_ADDR);
  end
  assign pslverr = psel & penable & ~hit;

  // Edge selection: bit set picks the rising edge, clear the falling edge
  assign event_zero = edge_select[0] ? pins.rise[0] : pins.fall[0];
  assign event_one  = edge_select[1] ? pins.rise[1] : pins.fall[1];
  assign event_key  = |pins.fall[NPINS-1:2];
  assign events     = {event_key, event_one, event_zero};

  // Servicing: dedicated ack inputs or a write of ones to the ack register
  assign ack_zero = pin_zero_service_ack |
                    (wr && addr == `SERVICE_ACK_ADDR &&
                     pwdata[`PIN_ZERO_REQ_BIT]);
  assign ack_one  = pin_one_service_ack |
                    (wr && addr == `SERVICE_ACK_ADDR &&
                     pwdata[`PIN_ONE_REQ_BIT]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_select <= `EDGE_SELECT_RESET;
    end else if (wr && addr == `EDGE_SELECT_ADDR) begin
      edge_select <= pwdata[1:0];
    end
  end

  // Pin zero/one flag register; a new edge wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_flags <= `PIN01_FLAGS_RESET;
    end else begin
      if (wr && addr == `PIN01_FLAGS_ADDR) begin
        pin_flags <= pwdata[3:0];
      end
      if (ack_zero) begin
        pin_flags[`PIN_ZERO_REQ_BIT] <= 1'b0;
      end
      if (ack_one) begin
        pin_flags[`PIN_ONE_REQ_BIT] <= 1'b0;
      end
      if (event_zero) begin
        pin_flags[`PIN_ZERO_REQ_BIT] <= 1'b1;
      end
      if (event_one) begin
        pin_flags[`PIN_ONE_REQ_BIT] <= 1'b1;
      end
    end
  end

  // Key-scan flags; request has no hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {key_scan_irq_enable, key_scan_irq_request} <= `KEY_SCAN_RESET;
    end else begin
      if (wr && addr == `KEY_SCAN_FLAGS_ADDR) begin
        key_scan_irq_enable  <= pwdata[`KEY_SCAN_EN_BIT];
        key_scan_irq_request <= pwdata[`KEY_SCAN_REQ_BIT];
      end
      if (event_key) begin
        key_scan_irq_request <= 1'b1;
      end
    end
  end

  // Sticky event status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `STATUS_RESET;
    end else if (wr && addr == `IRQ_STATUS_ADDR) begin
      irq_status <= (irq_status & ~pwdata[2:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `MASK_RESET;
    end else if (wr && addr == `IRQ_MASK_ADDR) begin
      irq_mask <= pwdata[2:0];
    end
  end

  // Requests toward the processor: per-source outputs gated by enables, irq by irq_mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_zero_irq    <= 1'b0;
      pin_one_irq     <= 1'b0;
      key_scan_source <= 1'b0;
      irq             <= 1'b0;
    end else begin
      pin_zero_irq    <= next_zero_irq(pin_flags);
      pin_one_irq     <= pin_flags[`PIN_ONE_EN_BIT] &
                         pin_flags[`PIN_ONE_REQ_BIT];
      key_scan_source <= key_scan_irq_enable & key_scan_irq_request;
      irq             <= |(next_status(irq_status, events) & irq_mask);
    end
  end

  function automatic logic next_zero_irq(input logic [3:0] f);
    return f[`PIN_ZERO_EN_BIT] & f[`PIN_ZERO_REQ_BIT];
  endfunction

  function automatic src_vec_t next_status(input src_vec_t s,
                                           input src_vec_t e);
    return s | e;
  endfunction

  // Read data registered in the setup cycle, valid during access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr[13:0])
        `PIN01_FLAGS_ADDR:    prdata <= {28'h0, pin_flags};
        `KEY_SCAN_FLAGS_ADDR: prdata <= {30'h0, key_scan_irq_enable,
                                         key_scan_irq_request};
        `IRQ_STATUS_ADDR:     prdata <= {29'h0, irq_status};
        `IRQ_MASK_ADDR:       prdata <= {29'h0, irq_mask};
        `EDGE_SELECT_ADDR:    prdata <= {30'h0, edge_select};
        default:              prdata <= 32'h0;
      endcase
    end
  end
endmodule

// [bench/flags_check_assertions.sv]
// Assertions on the pin interrupt flag block, bound to its top module.
// Assumes zero-wait APB and registered interrupt outputs.
`timescale 1ns/10ps
`include "ext_pin_irq_regs.svh"
module flags_check (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        pin_zero_service_ack,
  input wire logic        pin_zero_irq,
  input wire logic        pin_one_irq,
  input wire logic        key_scan_source,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, wp, wk;
  assign acc = psel && penable;
  assign wp  = acc && pwrite && paddr == 32'(`PIN01_FLAGS_ADDR);
  assign wk  = acc && pwrite && paddr == 32'(`KEY_SCAN_FLAGS_ADDR);
  err_in_access_a: assert property (pslverr |-> acc)
    else $error("error outside access");
  err_mapped_a: assert property (wp || wk |-> !pslverr)
    else $error("error on mapped write");
  err_unmapped_a: assert property (
    acc && paddr[31:14] != 0 |-> pslverr) else $error("no error");
  zero_on_a: assert property (
    wp && pwdata[1:0] == 2'h3 |-> ##[1:2] pin_zero_irq)
    else $error("pin zero irq missing");
  one_off_a: assert property (wp && !pwdata[3] |-> ##2 !pin_one_irq)
    else $error("pin one irq not blocked");
  zero_ack_a: assert property (
    pin_zero_service_ack |-> ##[1:2] !pin_zero_irq)
    else $error("pin zero not cleared");
  key_on_a: assert property (
    wk && pwdata[1:0] == 2'h3 |-> ##[1:2] key_scan_source)
    else $error("key source missing");
  key_hold_a: assert property (
    key_scan_source && !wk && !$past(wk) |=> key_scan_source)
    else $error("key request dropped");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property ($fell(key_scan_source));
endmodule
bind ext_pin_interrupt_flags flags_check chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pslverr, .pin_zero_service_ack,
  .pin_zero_irq, .pin_one_irq, .key_scan_source, .irq);

// [bench/pin_model.sv]
// Model of the pins: key-scan group in bits 7-0, edge pins in 8 and 9.
// Assumes pull-ups, so a released pin rests high.
`timescale 1ns/10ps
module pin_model (
  input  wire logic       pclk,
  output logic      [9:0] pin_lvl
);
  initial pin_lvl = 10'h3FF;
  task automatic hold(input int idx, input logic lvl);
    @(posedge pclk);
    pin_lvl[idx] <= lvl;
  endtask
  task automatic press(input int idx);
    @(posedge pclk);
    pin_lvl[idx] <= 1'b0;
    repeat (4) @(posedge pclk);
    pin_lvl[idx] <= 1'b1;
  endtask
endmodule

// [bench/tb.sv]
// Self-checking bench for the pin interrupt flag block.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`include "ext_pin_irq_regs.svh"
module tb;
  localparam logic [31:0] PF = 32'(`PIN01_FLAGS_ADDR);
  localparam logic [31:0] KF = 32'(`KEY_SCAN_FLAGS_ADDR);
  localparam logic [31:0] ST = 32'(`IRQ_STATUS_ADDR);
  localparam logic [31:0] MK = 32'(`IRQ_MASK_ADDR);
  localparam logic [31:0] SA = 32'(`SERVICE_ACK_ADDR);
  localparam logic [31:0] ES = 32'(`EDGE_SELECT_ADDR);
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, ack_zero = 1'b0, ack_one = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, zero_irq, one_irq, key_src, irq, err, lvl;
  logic [9:0]  pin_lvl;
  int          fails = 0;
  int          checks_done = 0;
  always #12.5 pclk = ~pclk;
  pin_model pm (.pclk, .pin_lvl);
  ext_pin_interrupt_flags uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_pin_zero(pin_lvl[8]),
    .ext_pin_one(pin_lvl[9]), .key_scan_inputs(pin_lvl[7:0]),
    .pin_zero_service_ack(ack_zero), .pin_one_service_ack(ack_one),
    .pin_zero_irq(zero_irq), .pin_one_irq(one_irq),
    .key_scan_source(key_src), .irq);
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %0h", $time, m, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp, m);
  endtask
  task automatic pin_edge(input int idx);
    pm.press(idx);
    repeat (6) @(posedge pclk);
  endtask
  task automatic pulse(input logic one);
    @(posedge pclk);
    if (one) ack_one <= 1'b1; else ack_zero <= 1'b1;
    @(posedge pclk);
    ack_one  <= 1'b0;
    ack_zero <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(PF, 32'h0, "pin flags reset");
    rd(KF, 32'h0, "key flags reset");
    apb(1'b1, PF, 32'h3);
    repeat (2) @(posedge pclk);
    chk(zero_irq, 32'h1, "soft request");
    apb(1'b1, PF, 32'hA);
    rd(PF, 32'hA, "enables kept");
    pin_edge(8);
    rd(PF, 32'hB, "zero edge");
    chk(zero_irq, 32'h1, "zero passed");
    pulse(1'b0);
    rd(PF, 32'hA, "zero serviced");
    chk(zero_irq, 32'h0, "zero irq gone");
    apb(1'b1, PF, 32'h0);
    pin_edge(9);
    rd(PF, 32'h4, "one edge");
    chk(one_irq, 32'h0, "one blocked");
    pulse(1'b1);
    rd(PF, 32'h0, "one serviced");
    pin_edge(8);
    apb(1'b1, SA, 32'h1);
    rd(PF, 32'h0, "ack register");
    $display("dedicated pin test done");
    for (int i = 0; i < 8; i++) begin
      pin_edge(i);
      rd(KF, 32'h1, "key edge");
      chk(key_src, 32'h0, "key blocked");
      apb(1'b1, SA, 32'h5);
      rd(KF, 32'h1, "key kept");
      apb(1'b1, KF, 32'h0);
    end
    rd(KF, 32'h0, "key cleared");
    apb(1'b1, KF, 32'h2);
    pin_edge(7);
    chk(key_src, 32'h1, "key passed");
    rd(KF, 32'h3, "key layout");
    apb(1'b1, KF, 32'h3);
    $display("key scan test done");
    rd(ST, 32'h7, "status sticky");
    apb(1'b1, MK, 32'h0);
    repeat (2) @(posedge pclk);
    lvl = irq;
    apb(1'b1, MK, 32'h7);
    repeat (2) @(posedge pclk);
    chk(lvl, 32'h0, "irq masked");
    chk(irq, 32'h1, "irq unmasked");
    apb(1'b1, ST, 32'h7);
    rd(ST, 32'h0, "status cleared");
    chk(err, 32'h0, "mapped no error");
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0, "irq cleared");
    rd(32'h10000, 32'h0, "unmapped data");
    chk(err, 32'h1, "unmapped error");
    $display("interrupt and bus test done");
    apb(1'b1, ES, 32'h1);
    pm.hold(8, 1'b0);
    repeat (6) @(posedge pclk);
    rd(PF, 32'h0, "falling ignored");
    pm.hold(8, 1'b1);
    repeat (6) @(posedge pclk);
    rd(PF, 32'h1, "rising edge");
    chk(irq, 32'h1, "rising status");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(PF, 32'h0, "flags after reset");
    chk(irq, 32'h0, "irq after reset");
    $display("edge select and reset test done");
    final_report();
  end
  initial begin
    repeat (4000) @(posedge pclk);
    fails++;
    final_report();
  end
endmodule
